// [core/lsdc_regs.sv]
// Purpose: Read-only link status and device capabilities-2 registers on a plain register port
// Assumes: One-cycle strobes, read data valid only in the cycle after the read strobe
// Notes: Writes are accepted and discarded; unmapped reads return zero
//
// Function
// - Link status bit 12 shows shared connector reference clock versus independent clock.
// - Link status bits 9:4 report the negotiated lane width; undefined while down.
// - Link status bits 3:0 report the negotiated link speed; undefined while down.
// - Bits 23:22 give maximum end-to-end prefixes; excess prefixes mean malformed packet.
// - Bit 21 is one only when end-to-end prefixes are accepted.
// - Bit 20 is one when the three-bit format field is decoded.
// - Bits 19:18 advertise the implemented buffer flush support level.
// - Bits 13:12 hint completer: 00 none, 01 basic, 11 both; 10 reserved.
// - Bit 11 is one when latency reporting is implemented.
// - Relaxed passing, atomic routing and alternate forwarding bits always read zero.
// - Bit 9 is one when 128-bit compare-and-swap completion is supported.
// - Bit 8 is one when 64-bit atomic completion is supported.
// - Bit 7 is one when 32-bit atomic completion is supported.
// - Bit 4 resets to one: completion-timeout disable is supported.
// - Bits 3:0 indicate the supported programmable completion-timeout ranges.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module lsdc_regs #(
    parameter logic SLOT_CLOCK_SHARED = 1'b1,
    parameter logic [1:0] PREFIX_MAX = 2'h0,
    parameter logic PREFIX_SUPPORTED = 1'b0,
    parameter logic EXT_FORMAT_SUPPORTED = 1'b0,
    parameter logic [1:0] FLUSH_SUPPORT = 2'h0,
    parameter logic [1:0] HINT_COMPLETER = 2'h0,
    parameter logic LATENCY_REPORT = 1'b0,
    parameter logic WIDE_SWAP = 1'b0,
    parameter logic ATOMIC64 = 1'b0,
    parameter logic ATOMIC32 = 1'b0,
    parameter logic [3:0] TIMEOUT_RANGES = 4'h0
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [lsdc_pkg::LSDC_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic link_up,
    input wire logic [5:0] trained_width,
    input wire logic [3:0] trained_speed,
    output logic malformed_prefix,
    input wire logic rx_tlp_valid,
    input wire logic [2:0] rx_prefix_count
);
    // Reserved encoding must never be advertised; refused while elaborating, not at run time
    if (HINT_COMPLETER == lsdc_pkg::LSDC_TPH_RSVD) begin : g_bad_hint
        $error("HINT_COMPLETER 2'b10 is a reserved encoding");
    end
    if (PREFIX_SUPPORTED == 1'b0 && PREFIX_MAX != 2'h0) begin : g_bad_prefix
        $error("PREFIX_MAX needs PREFIX_SUPPORTED");
    end

    logic [5:0] negotiated_width;
    logic [3:0] negotiated_speed;
    logic timeout_disable_sup;
    logic [15:0] link_status;
    logic [31:0] device_capabilities_two;
    logic hit_ls;
    logic hit_c2;
    logic [31:0] next_rdata;
    logic [2:0] prefix_limit;
    logic next_malformed;
    logic unused_write;

    lsdc_link_capture u_capture (
        .mclk(mclk),
        .rst_n(rst_n),
        .link_up(link_up),
        .trained_width(trained_width),
        .trained_speed(trained_speed),
        .negotiated_width(negotiated_width),
        .negotiated_speed(negotiated_speed)
    );

    // Timeout-disable support bit takes its value at reset and then holds
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            timeout_disable_sup <= lsdc_pkg::LSDC_TODIS_RESET;
        end else begin
            timeout_disable_sup <= timeout_disable_sup;
        end
    end

    // Link status image; every bit not assigned stays zero
    always_comb begin
        link_status = 16'h0000;
        link_status[lsdc_pkg::LSDC_LS_SLOTCLK_BIT] = SLOT_CLOCK_SHARED;
        link_status[lsdc_pkg::LSDC_LS_WIDTH_LSB +: lsdc_pkg::LSDC_LS_WIDTH_W] = negotiated_width;
        link_status[lsdc_pkg::LSDC_LS_SPEED_LSB +: lsdc_pkg::LSDC_LS_SPEED_W] = negotiated_speed;
    end

    // Capabilities-2 image; reserved and not-applicable bits stay zero
    always_comb begin
        device_capabilities_two = 32'h0000_0000;
        device_capabilities_two[lsdc_pkg::LSDC_C2_PREFIX_MAX_LSB +: 2] = PREFIX_MAX;
        device_capabilities_two[lsdc_pkg::LSDC_C2_PREFIX_SUP_BIT] = PREFIX_SUPPORTED;
        device_capabilities_two[lsdc_pkg::LSDC_C2_EXTFMT_BIT] = EXT_FORMAT_SUPPORTED;
        device_capabilities_two[lsdc_pkg::LSDC_C2_FLUSH_LSB +: 2] = FLUSH_SUPPORT;
        device_capabilities_two[lsdc_pkg::LSDC_C2_TPH_LSB +: 2] = HINT_COMPLETER;
        device_capabilities_two[lsdc_pkg::LSDC_C2_LTR_BIT] = LATENCY_REPORT;
        device_capabilities_two[lsdc_pkg::LSDC_C2_RELAX_BIT] = lsdc_pkg::LSDC_NA_BIT;
        device_capabilities_two[lsdc_pkg::LSDC_C2_ROUTE_BIT] = lsdc_pkg::LSDC_NA_BIT;
        device_capabilities_two[lsdc_pkg::LSDC_C2_ARIFWD_BIT] = lsdc_pkg::LSDC_NA_BIT;
        device_capabilities_two[lsdc_pkg::LSDC_C2_CAS128_BIT] = WIDE_SWAP;
        device_capabilities_two[lsdc_pkg::LSDC_C2_AT64_BIT] = ATOMIC64;
        device_capabilities_two[lsdc_pkg::LSDC_C2_AT32_BIT] = ATOMIC32;
        device_capabilities_two[lsdc_pkg::LSDC_C2_TODIS_BIT] = timeout_disable_sup;
        device_capabilities_two[lsdc_pkg::LSDC_C2_TORANGE_LSB +: 4] = TIMEOUT_RANGES;
    end

    // Address decode; index compare covers the upper bits too
    assign hit_ls = reg_addr == {2'h0, lsdc_pkg::LSDC_OFS_LINK_STATUS};
    assign hit_c2 = reg_addr == {2'h0, lsdc_pkg::LSDC_OFS_DEVCAP2};
    assign next_rdata = !reg_rd ? 32'h0000_0000 :
                        hit_ls ? {16'h0000, link_status} :
                        hit_c2 ? device_capabilities_two : 32'h0000_0000;

    // Writes carry no storage; the strobe and data are deliberately dropped
    assign unused_write = reg_wr & (|reg_wdata);

    // Read data register: valid only in the cycle after the strobe
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0000_0000;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    // Prefix count check: more prefixes than advertised makes the packet malformed
    assign prefix_limit = PREFIX_SUPPORTED ? {1'b0, PREFIX_MAX} : 3'h0;
    assign next_malformed = rx_tlp_valid && (rx_prefix_count > prefix_limit);

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            malformed_prefix <= 1'b0;
        end else begin
            malformed_prefix <= next_malformed;
        end
    end
endmodule
`default_nettype wire

// [core/lsdc_pkg.sv]
// Purpose: Shared constants for the link status and capabilities-2 register bank
// Assumes: Register port with word-indexed offsets relative to the express capability base
// Notes: Offsets are the printed capability offsets; byte address is four times the index
package lsdc_pkg;
    // Register indices (printed offsets are not all multiples of four)
    localparam logic [7:0] LSDC_OFS_LINK_STATUS = 8'h12;
    localparam logic [7:0] LSDC_OFS_DEVCAP2 = 8'h24;
    localparam int LSDC_ADDR_W = 10;
    // Link status field positions
    localparam int LSDC_LS_SLOTCLK_BIT = 12;
    localparam int LSDC_LS_WIDTH_LSB = 4;
    localparam int LSDC_LS_WIDTH_W = 6;
    localparam int LSDC_LS_SPEED_LSB = 0;
    localparam int LSDC_LS_SPEED_W = 4;
    // Capabilities-2 field positions
    localparam int LSDC_C2_PREFIX_MAX_LSB = 22;
    localparam int LSDC_C2_PREFIX_SUP_BIT = 21;
    localparam int LSDC_C2_EXTFMT_BIT = 20;
    localparam int LSDC_C2_FLUSH_LSB = 18;
    localparam int LSDC_C2_TPH_LSB = 12;
    localparam int LSDC_C2_LTR_BIT = 11;
    localparam int LSDC_C2_RELAX_BIT = 10;
    localparam int LSDC_C2_CAS128_BIT = 9;
    localparam int LSDC_C2_AT64_BIT = 8;
    localparam int LSDC_C2_AT32_BIT = 7;
    localparam int LSDC_C2_ROUTE_BIT = 6;
    localparam int LSDC_C2_ARIFWD_BIT = 5;
    localparam int LSDC_C2_TODIS_BIT = 4;
    localparam int LSDC_C2_TORANGE_LSB = 0;
    // Processing hint completer encodings
    localparam logic [1:0] LSDC_TPH_NONE = 2'h0;
    localparam logic [1:0] LSDC_TPH_BASIC = 2'h1;
    localparam logic [1:0] LSDC_TPH_RSVD = 2'h2;
    localparam logic [1:0] LSDC_TPH_BOTH = 2'h3;
    // Fixed values of the hardwired bits
    localparam logic LSDC_TODIS_RESET = 1'b1;
    localparam logic LSDC_NA_BIT = 1'b0;
    // Reset values of the captured link outcome
    localparam logic [5:0] LSDC_WIDTH_RESET = 6'h00;
    localparam logic [3:0] LSDC_SPEED_RESET = 4'h0;
endpackage

// [core/lsdc_link_capture.sv]
// Purpose: Holds the negotiated lane width and speed reported by link training
// Assumes: Training outcome inputs are synchronous to mclk
// Notes: Values freeze while the link is down so reads stay steady
`timescale 1ns/1ps
`default_nettype none
module lsdc_link_capture (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic link_up,
    input wire logic [5:0] trained_width,
    input wire logic [3:0] trained_speed,
    output logic [5:0] negotiated_width,
    output logic [3:0] negotiated_speed
);
    logic [5:0] next_width;
    logic [3:0] next_speed;

    // Track training only while up; field is undefined when down, so holding is legal
    assign next_width = link_up ? trained_width : negotiated_width;
    assign next_speed = link_up ? trained_speed : negotiated_speed;

    // Captured outcome registers
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            negotiated_width <= lsdc_pkg::LSDC_WIDTH_RESET;
            negotiated_speed <= lsdc_pkg::LSDC_SPEED_RESET;
        end else begin
            negotiated_width <= next_width;
            negotiated_speed <= next_speed;
        end
    end
endmodule
`default_nettype wire

// [test/lsdc_regs_chk.sv]
// Purpose: Port checker for the link status and capabilities-2 register bank
// Assumes: One clock, synchronous active-low reset
// Notes: Prefix ceiling mirrors the design parameters handed on by the bind
`timescale 1ns/1ps
`default_nettype none
module lsdc_regs_chk #(
    parameter logic [1:0] PREFIX_MAX = 2'h0,
    parameter logic PREFIX_SUPPORTED = 1'b0
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [lsdc_pkg::LSDC_ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic link_up,
    input wire logic [5:0] trained_width,
    input wire logic [3:0] trained_speed,
    input wire logic malformed_prefix,
    input wire logic rx_tlp_valid,
    input wire logic [2:0] rx_prefix_count
);
    // Register indices and prefix ceiling; ceiling is zero when prefixes are refused
    localparam logic [9:0] LS = 10'(lsdc_pkg::LSDC_OFS_LINK_STATUS);
    localparam logic [9:0] C2 = 10'(lsdc_pkg::LSDC_OFS_DEVCAP2);
    localparam logic [2:0] LIM = PREFIX_SUPPORTED ? {1'b0, PREFIX_MAX} : 3'h0;
    wire logic rd_ls = reg_rd && reg_addr == LS;
    wire logic rd_c2 = reg_rd && reg_addr == C2;
    wire logic over = rx_tlp_valid && rx_prefix_count > LIM;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    property p_idle; !reg_rd |=> reg_rdata == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("read data not idle");
    property p_ls_rsvd; rd_ls |=> reg_rdata[31:13] == 19'h0 && reg_rdata[11:10] == 2'h0; endproperty
    a_ls_rsvd: assert property (p_ls_rsvd) else $error("link status reserved bits set");
    property p_slot; rd_ls |=> reg_rdata[12]; endproperty
    a_slot: assert property (p_slot) else $error("slot clock bit wrong");
    property p_width; link_up ##1 (link_up && rd_ls) |=> reg_rdata[9:4] == $past(trained_width, 2); endproperty
    a_width: assert property (p_width) else $error("negotiated width wrong");
    property p_speed; link_up ##1 (link_up && rd_ls) |=> reg_rdata[3:0] == $past(trained_speed, 2); endproperty
    a_speed: assert property (p_speed) else $error("negotiated speed wrong");
    property p_c2_fixed; rd_c2 |=> reg_rdata[31:24] == 8'h0 && reg_rdata[17:14] == 4'h0 && !reg_rdata[10]
        && reg_rdata[6:4] == 3'h1; endproperty
    a_c2_fixed: assert property (p_c2_fixed) else $error("capabilities-2 fixed bits wrong");
    property p_pfx_bad; over |=> malformed_prefix ##1 !malformed_prefix || $past(over); endproperty
    a_pfx_bad: assert property (p_pfx_bad) else $error("excess prefixes not flagged");
    property p_pfx_ok; !over |=> !malformed_prefix; endproperty
    a_pfx_ok: assert property (p_pfx_ok) else $error("prefix flag without cause");
    property p_wr; rd_c2 ##1 reg_wr ##1 rd_c2 |=> reg_rdata == $past(reg_rdata, 2); endproperty
    a_wr: assert property (p_wr) else $error("write changed capabilities-2");
endmodule
bind lsdc_regs lsdc_regs_chk #(.PREFIX_MAX(PREFIX_MAX), .PREFIX_SUPPORTED(PREFIX_SUPPORTED)) chk_u (.mclk,
    .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_rdata, .link_up, .trained_width, .trained_speed,
    .malformed_prefix, .rx_tlp_valid, .rx_prefix_count);
`default_nettype wire

// [test/lsdc_regs_tb_top.sv]
// Purpose: Self-checking bench for the link status and capabilities-2 bank
// Assumes: Five parameters moved off their defaults; the other fields read at their defaults, zero except slot clock and timeout disable
// Notes: Prefix ceiling is 2, so counts 3 to 7 must be flagged
`timescale 1ns/1ps
`default_nettype none
module lsdc_regs_tb_top;
    logic mclk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, link_up = 1'b0, rx_tlp_valid = 1'b0;
    logic [9:0] reg_addr = 10'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata;
    logic [5:0] trained_width = 6'h0;
    logic [3:0] trained_speed = 4'h0;
    logic [2:0] rx_prefix_count = 3'h0;
    logic malformed_prefix;
    int error_cnt = 0, samples_checked = 0;
    // 40 MHz clock
    always #12.5 mclk = ~mclk;
    lsdc_regs #(.PREFIX_MAX(2'h2), .PREFIX_SUPPORTED(1'b1), .FLUSH_SUPPORT(2'h1),
        .HINT_COMPLETER(2'h3), .TIMEOUT_RANGES(4'hA)) dut_u (.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata,
        .link_up, .trained_width, .trained_speed, .malformed_prefix, .rx_tlp_valid, .rx_prefix_count);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One-cycle strobe, data judged in the following cycle only
    task automatic rd(input logic [9:0] a, input logic [31:0] exp);
        @(posedge mclk) begin reg_rd <= 1'b1; reg_addr <= a; end
        @(posedge mclk) reg_rd <= 1'b0;
        @(negedge mclk) chk(reg_rdata, exp);
    endtask
    task automatic wr(input logic [9:0] a);
        @(posedge mclk) begin reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= 32'hFFFFFFFF; end
        @(posedge mclk) reg_wr <= 1'b0;
    endtask
    // Read, write, read with no gap: the write in between must not disturb either read
    task automatic rwr(input logic [9:0] a, input logic [31:0] exp);
        @(posedge mclk) begin reg_rd <= 1'b1; reg_addr <= a; end
        @(posedge mclk) begin reg_rd <= 1'b0; reg_wr <= 1'b1; reg_wdata <= 32'hFFFFFFFF; end
        @(negedge mclk) chk(reg_rdata, exp);
        @(posedge mclk) begin reg_wr <= 1'b0; reg_rd <= 1'b1; end
        @(posedge mclk) reg_rd <= 1'b0;
        @(negedge mclk) chk(reg_rdata, exp);
    endtask
    task automatic t_link();
        rd(10'h012, 32'h00001000);
        @(posedge mclk) begin link_up <= 1'b1; trained_width <= 6'h08; trained_speed <= 4'h3; end
        rd(10'h012, 32'h00001083);
        @(posedge mclk) begin link_up <= 1'b0; trained_width <= 6'h01; trained_speed <= 4'h1; end
        rd(10'h012, 32'h00001083);
    endtask
    // Fields packed: prefix 2, prefix on, flush 1, hint both, disable, ranges A; the rest stay zero
    task automatic t_caps();
        rd(10'h024, 32'h00A4301A);
        rwr(10'h024, 32'h00A4301A);
        wr(10'h012);
        rd(10'h012, 32'h00001083);
        rd(10'h013, 32'h0);
    endtask
    task automatic t_prefix();
        for (int c = 0; c < 8; c++) begin
            @(posedge mclk) begin rx_tlp_valid <= 1'b1; rx_prefix_count <= 3'(c); end
            @(posedge mclk) rx_tlp_valid <= 1'b0;
            @(negedge mclk) chk({31'h0, malformed_prefix}, {31'h0, c > 2});
        end
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        t_link();
        t_caps();
        t_prefix();
        close_out();
    end
    // Whole run needs well under 200 cycles
    initial begin
        #20us;
        error_cnt++;
        close_out();
    end
endmodule
`default_nettype wire
